// *** core/lcr_cfg.svh ***
`ifndef LCR_CFG_SVH
`define LCR_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define LCR_OFS_STAGGER    8'h05
`define LCR_OFS_AMP_LOW    8'h06
`define LCR_OFS_MAX_AMP_HI 8'h07
`define LCR_OFS_AUX_EN     8'h08
`define LCR_OFS_TRANS_CFG  8'h09

// ----------------------------------------
// reset values and writable bits
// ----------------------------------------
`define LCR_RST_STAGGER    8'h38
`define LCR_RST_AMP_LOW    8'hFF
`define LCR_RST_MAX_AMP_HI 8'h3F
`define LCR_RST_AUX_EN     8'hA7
`define LCR_RST_TRANS_CFG  8'h82
`define LCR_WM_STAGGER     8'h38
`define LCR_WM_AMP_LOW     8'hFF
`define LCR_WM_MAX_AMP_HI  8'h7F
`define LCR_WM_AUX_EN      8'hF7
`define LCR_WM_TRANS_CFG   8'hFF

// ----------------------------------------
// field positions
// ----------------------------------------
`define LCR_PS_MSB   5
`define LCR_PS_LSB   3
`define LCR_AMPH_MSB 3
`define LCR_AMPH_LSB 0
`define LCR_CEIL_MSB 6
`define LCR_CEIL_LSB 4
`define LCR_MIX_TRANSFER_POINT_MSB 7
`define LCR_MIX_TRANSFER_POINT_LSB 6
`define LCR_INPUT_LOCKOUT_ENABLE  5
`define LCR_UVLO_LVL 4
`define LCR_EXT_CURRENT_RESISTOR_ENABLE  2
`define LCR_FSW_EN   1
`define LCR_FDIM_EN  0
`define LCR_RANGE    7
`define LCR_TT_MSB   6
`define LCR_TT_LSB   4
`define LCR_FLT_MSB  3
`define LCR_FLT_LSB  2
`define LCR_HY_MSB   1
`define LCR_HY_LSB   0

// ----------------------------------------
// codes and serial framing
// ----------------------------------------
`define LCR_DIMMING_MODE_SELECT_PWM 2'h0
`define LCR_DIMMING_MODE_SELECT_MIX 2'h2
`define LCR_PS_OFF   3'h7
`define LCR_ACK_SLOT 4'h8

`endif

// *** core/lcr_pkg.sv ***
package lcr_pkg;
	typedef enum logic [2:0] {
		LCR_IDLE,
		LCR_ADDR,
		LCR_PTR,
		LCR_WR,
		LCR_RD,
		LCR_IGNORE
	} lcr_bus_state_t;
endpackage

// *** core/lcr_serial_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lcr_cfg.svh"

module lcr_serial_slave #(
	// arbitrary bus address
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	input  wire logic [7:0] rd_data_i,
	output logic [7:0]      ptr_o,
	output logic            wr_stb_o,
	output logic [7:0]      wr_addr_o,
	output logic [7:0]      wr_data_o
);

	lcr_pkg::lcr_bus_state_t state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic       ack_done_r, ack_done_nxt;
	logic       mack_r, mack_nxt;
	logic [7:0] sh_r, sh_nxt;
	logic [7:0] ptr_r, ptr_nxt;
	logic       oe_r, oe_nxt;
	logic       scl_q, sda_q;
	logic       wr_stb_r, wr_stb_nxt;
	logic [7:0] wr_addr_r, wr_addr_nxt;
	logic [7:0] wr_data_r, wr_data_nxt;
	logic       scl_rise, scl_fall, start_c, stop_c;

	// ----------------------------------------
	// byte framing
	// ----------------------------------------
	always_comb
	begin
		scl_rise     = scl_i & ~scl_q;
		scl_fall     = ~scl_i & scl_q;
		start_c      = scl_i & scl_q & sda_q & ~sda_i;
		stop_c       = scl_i & scl_q & ~sda_q & sda_i;
		state_nxt    = state_r;
		cnt_nxt      = cnt_r;
		ack_done_nxt = ack_done_r;
		mack_nxt     = mack_r;
		sh_nxt       = sh_r;
		ptr_nxt      = ptr_r;
		oe_nxt       = oe_r;
		wr_stb_nxt   = 1'b0;
		wr_addr_nxt  = wr_addr_r;
		wr_data_nxt  = wr_data_r;
		if (start_c)
		begin
			state_nxt    = lcr_pkg::LCR_ADDR;
			cnt_nxt      = 4'h0;
			ack_done_nxt = 1'b0;
			oe_nxt       = 1'b0;
		end
		else if (stop_c)
		begin
			state_nxt = lcr_pkg::LCR_IDLE;
			oe_nxt    = 1'b0;
		end
		else if (state_r != lcr_pkg::LCR_IDLE && scl_rise)
		begin
			if (cnt_r != `LCR_ACK_SLOT)
			begin
				if (state_r != lcr_pkg::LCR_RD)
					sh_nxt = {sh_r[6:0], sda_i};
				cnt_nxt = cnt_r + 4'h1;
			end
			else
			begin
				ack_done_nxt = 1'b1;
				mack_nxt     = sda_i;
			end
		end
		else if (state_r != lcr_pkg::LCR_IDLE && scl_fall)
		begin
			if (cnt_r == `LCR_ACK_SLOT && !ack_done_r)
			begin
				case (state_r)
				lcr_pkg::LCR_ADDR:
					if (sh_r[7:1] == DEV_ADDR)
					begin
						oe_nxt    = 1'b1;
						mack_nxt  = 1'b0;
						state_nxt = sh_r[0] ? lcr_pkg::LCR_RD
						                    : lcr_pkg::LCR_PTR;
					end
					else
						state_nxt = lcr_pkg::LCR_IGNORE;
				lcr_pkg::LCR_PTR:
				begin
					ptr_nxt   = sh_r;
					oe_nxt    = 1'b1;
					state_nxt = lcr_pkg::LCR_WR;
				end
				lcr_pkg::LCR_WR:
				begin
					wr_stb_nxt  = 1'b1;
					wr_addr_nxt = ptr_r;
					wr_data_nxt = sh_r;
					ptr_nxt     = ptr_r + 8'h01;
					oe_nxt      = 1'b1;
				end
				default:
					oe_nxt = 1'b0;
				endcase
			end
			else if (cnt_r == `LCR_ACK_SLOT)
			begin
				cnt_nxt      = 4'h0;
				ack_done_nxt = 1'b0;
				oe_nxt       = 1'b0;
				// a master nack ends the read burst
				if (state_r == lcr_pkg::LCR_RD && !mack_r)
				begin
					sh_nxt  = rd_data_i;
					ptr_nxt = ptr_r + 8'h01;
					oe_nxt  = ~rd_data_i[7];
				end
				else if (state_r == lcr_pkg::LCR_RD)
					state_nxt = lcr_pkg::LCR_IGNORE;
			end
			else if (state_r == lcr_pkg::LCR_RD)
			begin
				sh_nxt = {sh_r[6:0], 1'b0};
				oe_nxt = ~sh_r[6];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_r    <= lcr_pkg::LCR_IDLE;
			cnt_r      <= 4'h0;
			ack_done_r <= 1'b0;
			mack_r     <= 1'b0;
			sh_r       <= 8'h00;
			ptr_r      <= 8'h00;
			oe_r       <= 1'b0;
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
			wr_stb_r   <= 1'b0;
			wr_addr_r  <= 8'h00;
			wr_data_r  <= 8'h00;
		end
		else
		begin
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			ack_done_r <= ack_done_nxt;
			mack_r     <= mack_nxt;
			sh_r       <= sh_nxt;
			ptr_r      <= ptr_nxt;
			oe_r       <= oe_nxt;
			scl_q      <= scl_i;
			sda_q      <= sda_i;
			wr_stb_r   <= wr_stb_nxt;
			wr_addr_r  <= wr_addr_nxt;
			wr_data_r  <= wr_data_nxt;
		end
	end

	// open drain: only ever pulls low
	assign sda_o     = 1'b0;
	assign sda_oe_o  = oe_r;
	assign ptr_o     = ptr_r;
	assign wr_stb_o  = wr_stb_r;
	assign wr_addr_o = wr_addr_r;
	assign wr_data_o = wr_data_r;

endmodule // lcr_serial_slave

`default_nettype wire

// *** core/lcr_cfg_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "lcr_cfg.svh"

module lcr_cfg_regs #(
	// arbitrary bus address
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic [1:0]  dimming_mode_select_i,
	input  wire logic        direct_pwm_i,
	output logic             mix_active_o,
	output logic             stagger_active_o,
	output logic [2:0]       stagger_phases_o,
	output logic [7:0]       stagger_step_deg_o,
	output logic [11:0]      amplitude_o,
	output logic [15:0]      current_ceiling_ua_o,
	output logic [15:0]      led_current_ua_o,
	output logic [9:0]       mix_transfer_permille_o,
	output logic             input_lockout_enable_o,
	output logic             input_lockout_level_o,
	output logic             ext_current_resistor_enable_o,
	output logic             ext_switch_freq_enable_o,
	output logic             ext_dim_freq_enable_o,
	output logic             output_range_select_o,
	output logic [9:0]       transition_time_ms_o,
	output logic [1:0]       smoothing_o,
	output logic [3:0]       hysteresis_bits_o
);

	logic [7:0]  ptr;
	logic        wr_stb;
	logic [7:0]  wr_addr;
	logic [7:0]  wr_data;
	logic [7:0]  rd_data;
	logic [7:0]  stag_r, stag_nxt;
	logic [7:0]  amp_lo_r, amp_lo_nxt;
	logic [7:0]  max_hi_r, max_hi_nxt;
	logic [7:0]  aux_r, aux_nxt;
	logic [7:0]  trans_r, trans_nxt;
	logic        mix_nxt, stag_act_nxt;
	logic [2:0]  phases_nxt;
	logic [7:0]  step_nxt;
	logic [11:0] amp_nxt;
	logic [15:0] ceil_nxt;
	logic [27:0] prod;
	logic [9:0]  mix_transfer_point_nxt;
	logic [9:0]  tt_nxt;
	logic [3:0]  hy_nxt;
	logic [2:0]  ps;

	lcr_serial_slave #(
		.DEV_ADDR (DEV_ADDR)
	) u_slave (
		.clk_i     (clk_i),
		.rst_b_i   (rst_b_i),
		.scl_i     (scl_i),
		.sda_i     (sda_i),
		.sda_o     (sda_o),
		.sda_oe_o  (sda_oe_o),
		.rd_data_i (rd_data),
		.ptr_o     (ptr),
		.wr_stb_o  (wr_stb),
		.wr_addr_o (wr_addr),
		.wr_data_o (wr_data)
	);

	// ----------------------------------------
	// read-back
	// ----------------------------------------
	// other offsets belong to neighbouring blocks, read zero here
	function automatic logic [7:0] rd_mux(input logic [7:0] a,
		input logic [7:0] s, input logic [7:0] l, input logic [7:0] h,
		input logic [7:0] x, input logic [7:0] t);
		if (a == `LCR_OFS_STAGGER)
			return s;
		else if (a == `LCR_OFS_AMP_LOW)
			return l;
		else if (a == `LCR_OFS_MAX_AMP_HI)
			return h;
		else if (a == `LCR_OFS_AUX_EN)
			return x;
		else if (a == `LCR_OFS_TRANS_CFG)
			return t;
		else
			return 8'h00;
	endfunction

	assign rd_data = rd_mux(ptr, stag_r, amp_lo_r, max_hi_r, aux_r,
		trans_r);

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always_comb
	begin
		stag_nxt   = stag_r;
		amp_lo_nxt = amp_lo_r;
		max_hi_nxt = max_hi_r;
		aux_nxt    = aux_r;
		trans_nxt  = trans_r;
		if (wr_stb)
		begin
			if (wr_addr == `LCR_OFS_STAGGER)
				stag_nxt = wr_data & `LCR_WM_STAGGER;
			else if (wr_addr == `LCR_OFS_AMP_LOW)
				amp_lo_nxt = wr_data & `LCR_WM_AMP_LOW;
			else if (wr_addr == `LCR_OFS_MAX_AMP_HI)
				max_hi_nxt = wr_data & `LCR_WM_MAX_AMP_HI;
			else if (wr_addr == `LCR_OFS_AUX_EN)
				aux_nxt = wr_data & `LCR_WM_AUX_EN;
			else if (wr_addr == `LCR_OFS_TRANS_CFG)
				trans_nxt = wr_data & `LCR_WM_TRANS_CFG;
		end
	end

	// ----------------------------------------
	// decoded settings
	// ----------------------------------------
	always_comb
	begin
		ps = stag_r[`LCR_PS_MSB:`LCR_PS_LSB];
		mix_nxt = (dimming_mode_select_i == `LCR_DIMMING_MODE_SELECT_MIX);
		stag_act_nxt = (ps != `LCR_PS_OFF) && (mix_nxt ||
			(dimming_mode_select_i == `LCR_DIMMING_MODE_SELECT_PWM && !direct_pwm_i));
		// code 101 taken as three groups
		case (ps)
		3'h0: begin phases_nxt = 3'h6; step_nxt = 8'h3C; end
		3'h1: begin phases_nxt = 3'h5; step_nxt = 8'h48; end
		3'h2: begin phases_nxt = 3'h4; step_nxt = 8'h5A; end
		3'h3: begin phases_nxt = 3'h3; step_nxt = 8'h78; end
		3'h4: begin phases_nxt = 3'h2; step_nxt = 8'hB4; end
		3'h5: begin phases_nxt = 3'h3; step_nxt = 8'h78; end
		3'h6: begin phases_nxt = 3'h2; step_nxt = 8'hB4; end
		default: begin phases_nxt = 3'h1; step_nxt = 8'h00; end
		endcase
		if (!stag_act_nxt)
		begin
			phases_nxt = 3'h1;
			step_nxt   = 8'h00;
		end
		amp_nxt = {max_hi_r[`LCR_AMPH_MSB:`LCR_AMPH_LSB], amp_lo_r};
		case (max_hi_r[`LCR_CEIL_MSB:`LCR_CEIL_LSB])
		3'h0: ceil_nxt = 16'h1388;
		3'h1: ceil_nxt = 16'h2710;
		3'h2: ceil_nxt = 16'h3A98;
		3'h3: ceil_nxt = 16'h4E20;
		3'h4: ceil_nxt = 16'h59D8;
		3'h5: ceil_nxt = 16'h61A8;
		3'h6: ceil_nxt = 16'h7530;
		default: ceil_nxt = 16'hC350;
		endcase
		prod = ceil_nxt * {16'h0000, amp_nxt};
		case (aux_r[`LCR_MIX_TRANSFER_POINT_MSB:`LCR_MIX_TRANSFER_POINT_LSB])
		2'h0: mix_transfer_point_nxt = 10'h07D;
		2'h1: mix_transfer_point_nxt = 10'h0C8;
		2'h2: mix_transfer_point_nxt = 10'h0FA;
		default: mix_transfer_point_nxt = 10'h1F4;
		endcase
		case (trans_r[`LCR_TT_MSB:`LCR_TT_LSB])
		3'h0: tt_nxt = 10'h000;
		3'h1: tt_nxt = 10'h001;
		3'h2: tt_nxt = 10'h002;
		3'h3: tt_nxt = 10'h032;
		3'h4: tt_nxt = 10'h064;
		3'h5: tt_nxt = 10'h0C8;
		3'h6: tt_nxt = 10'h12C;
		default: tt_nxt = 10'h1F4;
		endcase
		case (trans_r[`LCR_HY_MSB:`LCR_HY_LSB])
		2'h0: hy_nxt = 4'h0;
		2'h1: hy_nxt = 4'hD;
		2'h2: hy_nxt = 4'hC;
		default: hy_nxt = 4'h8;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			stag_r                        <= `LCR_RST_STAGGER;
			amp_lo_r                      <= `LCR_RST_AMP_LOW;
			max_hi_r                      <= `LCR_RST_MAX_AMP_HI;
			aux_r                         <= `LCR_RST_AUX_EN;
			trans_r                       <= `LCR_RST_TRANS_CFG;
			mix_active_o                  <= 1'b0;
			stagger_active_o              <= 1'b0;
			stagger_phases_o              <= 3'h1;
			stagger_step_deg_o            <= 8'h00;
			amplitude_o                   <= 12'hFFF;
			current_ceiling_ua_o          <= 16'h4E20;
			led_current_ua_o              <= 16'h4E1B;
			mix_transfer_permille_o       <= 10'h0FA;
			input_lockout_enable_o        <= 1'b1;
			input_lockout_level_o         <= 1'b0;
			ext_current_resistor_enable_o <= 1'b1;
			ext_switch_freq_enable_o      <= 1'b1;
			ext_dim_freq_enable_o         <= 1'b1;
			output_range_select_o         <= 1'b1;
			transition_time_ms_o          <= 10'h000;
			smoothing_o                   <= 2'h0;
			hysteresis_bits_o             <= 4'hC;
		end
		else
		begin
			stag_r                  <= stag_nxt;
			amp_lo_r                <= amp_lo_nxt;
			max_hi_r                <= max_hi_nxt;
			aux_r                   <= aux_nxt;
			trans_r                 <= trans_nxt;
			mix_active_o            <= mix_nxt;
			stagger_active_o        <= stag_act_nxt;
			stagger_phases_o        <= phases_nxt;
			stagger_step_deg_o      <= step_nxt;
			amplitude_o             <= amp_nxt;
			current_ceiling_ua_o    <= ceil_nxt;
			led_current_ua_o        <= prod[27:12];
			mix_transfer_permille_o <= mix_transfer_point_nxt;
			input_lockout_enable_o <= aux_r[`LCR_INPUT_LOCKOUT_ENABLE];
			input_lockout_level_o <= aux_r[`LCR_UVLO_LVL];
			ext_current_resistor_enable_o <= aux_r[`LCR_EXT_CURRENT_RESISTOR_ENABLE];
			ext_switch_freq_enable_o <= aux_r[`LCR_FSW_EN];
			ext_dim_freq_enable_o <= aux_r[`LCR_FDIM_EN];
			output_range_select_o <= trans_r[`LCR_RANGE];
			transition_time_ms_o  <= tt_nxt;
			smoothing_o       <= trans_r[`LCR_FLT_MSB:`LCR_FLT_LSB];
			hysteresis_bits_o <= hy_nxt;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	a_stagger_mode_gate: assert property (
		stagger_active_o |-> $past(dimming_mode_select_i) ==
		`LCR_DIMMING_MODE_SELECT_MIX || ($past(dimming_mode_select_i) ==
		`LCR_DIMMING_MODE_SELECT_PWM && !$past(direct_pwm_i)))
		else $error("stagger active outside indirect or mix mode");
	a_two_group_map: assert property (
		stag_r[`LCR_PS_MSB:`LCR_PS_LSB] == 3'h6 && mix_nxt |=>
		stagger_phases_o == 3'h2 && stagger_step_deg_o == 8'hB4)
		else $error("code 110 not two groups at 180");
	a_stagger_off: assert property (
		stag_r[`LCR_PS_MSB:`LCR_PS_LSB] == `LCR_PS_OFF |=>
		!stagger_active_o && stagger_step_deg_o == 8'h00)
		else $error("stagger not disabled by off code");
	a_amp_low_write: assert property (
		wr_stb && wr_addr == `LCR_OFS_AMP_LOW |=> ##1
		amplitude_o[7:0] == $past(wr_data, 2))
		else $error("amplitude low byte not applied");
	a_scaled_current: assert property (
		led_current_ua_o <= current_ceiling_ua_o)
		else $error("scaled current above ceiling");
	a_ceiling_top: assert property (
		max_hi_r[`LCR_CEIL_MSB:`LCR_CEIL_LSB] == 3'h7 |=>
		current_ceiling_ua_o == 16'hC350)
		else $error("ceiling code 111 not 50 mA");
	a_mix_transfer_point_low: assert property (
		aux_r[`LCR_MIX_TRANSFER_POINT_MSB:`LCR_MIX_TRANSFER_POINT_LSB] == 2'h0 |=>
		mix_transfer_permille_o == 10'h07D)
		else $error("transfer code 00 not 12.5 percent");
	a_lockout_write: assert property (
		wr_stb && wr_addr == `LCR_OFS_AUX_EN |=> ##1
		input_lockout_enable_o == $past(wr_data[`LCR_INPUT_LOCKOUT_ENABLE], 2))
		else $error("lockout enable not applied");
	a_transition_max: assert property (
		trans_r[`LCR_TT_MSB:`LCR_TT_LSB] == 3'h7 |=>
		transition_time_ms_o == 10'h1F4)
		else $error("transition code 111 not 500 ms");
	a_reserved_zero: assert property (
		wr_stb && wr_addr == `LCR_OFS_STAGGER |=>
		(stag_r & ~`LCR_WM_STAGGER) == 8'h00 &&
		max_hi_r[7] == 1'b0)
		else $error("reserved bits not zero");

	c_stagger_on: cover property (stagger_active_o);
	c_amp_write: cover property (wr_stb && wr_addr == `LCR_OFS_AMP_LOW);
	c_trans_write: cover property (wr_stb &&
		wr_addr == `LCR_OFS_TRANS_CFG);

endmodule // lcr_cfg_regs

`default_nettype wire

// *** verif/lcr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module lcr_host_model (
	input  wire logic clk_i,
	input  wire logic sda_oe_i,
	output logic      scl_o,
	output logic      sda_o
);
	// ----------------------------------------
	// wire level
	// ----------------------------------------
	logic sda_m;
	int   half;
	// pull-up: the device can only pull low
	assign sda_o = sda_m & ~sda_oe_i;

	initial
	begin
		scl_o = 1'b1;
		sda_m = 1'b1;
		half = 3;
	end

	// ----------------------------------------
	// bit, byte and frame tasks
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// data moves only while the clock is low
	task automatic bit_x(input logic b, output logic r);
		scl_o <= 1'b0;
		tick(1);
		sda_m <= b;
		tick(half);
		scl_o <= 1'b1;
		tick(half);
		r = sda_o;
		tick(1);
	endtask

	task automatic byte_x(input logic [7:0] d, input logic last,
		output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(d[i], r);
			q[i] = r;
		end
		bit_x(last, r);
		ack = ~r;
	endtask

	// also serves as a repeated start: the clock drops first so the
	// device leaves its ack slot and lets go of the line
	task automatic start();
		scl_o <= 1'b0;
		tick(1);
		sda_m <= 1'b1;
		tick(half);
		scl_o <= 1'b1;
		tick(half);
		sda_m <= 1'b0;
		tick(half);
	endtask

	task automatic stop();
		scl_o <= 1'b0;
		tick(1);
		sda_m <= 1'b0;
		tick(half);
		scl_o <= 1'b1;
		tick(half);
		sda_m <= 1'b1;
		tick(half);
	endtask

	task automatic write(input logic [6:0] dev, input logic [7:0] ptr,
		input logic [15:0] d, input int n, output logic ok);
		logic [7:0] q;
		logic       a0;
		logic       a1;
		start();
		byte_x({dev, 1'b0}, 1'b1, q, a0);
		byte_x(ptr, 1'b1, q, a1);
		ok = a0 & a1;
		byte_x(d[15:8], 1'b1, q, a1);
		if (n == 2)
			byte_x(d[7:0], 1'b1, q, a1);
		stop();
	endtask

	// pointer frame, repeated start, one byte ended by a nack
	task automatic read(input logic [6:0] dev, input logic [7:0] ptr,
		output logic [7:0] d);
		logic [7:0] q;
		logic       a;
		start();
		byte_x({dev, 1'b0}, 1'b1, q, a);
		byte_x(ptr, 1'b1, q, a);
		start();
		byte_x({dev, 1'b1}, 1'b1, q, a);
		byte_x(8'hFF, 1'b1, d, a);
		stop();
	endtask
endmodule // lcr_host_model

`default_nettype wire

// *** verif/tb_led_driver_config_regs_05_09.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_led_driver_config_regs_05_09;
	// ----------------------------------------
	// signals and expectation tables
	// ----------------------------------------
	localparam logic [6:0] DEV = 7'h2A;
	localparam int CEIL [8] = '{5000, 10000, 15000, 20000,
		23000, 25000, 30000, 50000};
	localparam int XFER [4] = '{125, 200, 250, 500};
	localparam int TT   [8] = '{0, 1, 2, 50, 100, 200, 300, 500};
	localparam int HY   [4] = '{0, 13, 12, 8};
	localparam int PH   [8] = '{6, 5, 4, 3, 2, 3, 2, 1};
	localparam int DEG  [8] = '{60, 72, 90, 120, 180, 120, 180, 0};
	localparam logic [7:0] WM  [5:9] = '{8'h38, 8'hFF, 8'h7F, 8'hF7, 8'hFF};
	localparam logic [7:0] RST [5:9] = '{8'h38, 8'hFF, 8'h3F, 8'hA7, 8'h82};

	logic        clk_i, rst_b_i, scl, sda, sda_oe, direct;
	logic [1:0]  mode, smooth;
	logic        mix_on, stg_on, lk_en, lk_lvl, r_iset, r_fsw, r_fdim, rng;
	logic [2:0]  stg_ph;
	logic [7:0]  stg_deg;
	logic [11:0] amp;
	logic [15:0] ceil, cur;
	logic [9:0]  xfer, ttime;
	logic [3:0]  hyst;
	logic [7:0]  sh [5:9];
	int          errors, total_checks;

	lcr_cfg_regs DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl),
		.sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
		.dimming_mode_select_i(mode), .direct_pwm_i(direct),
		.mix_active_o(mix_on), .stagger_active_o(stg_on),
		.stagger_phases_o(stg_ph), .stagger_step_deg_o(stg_deg),
		.amplitude_o(amp), .current_ceiling_ua_o(ceil),
		.led_current_ua_o(cur), .mix_transfer_permille_o(xfer),
		.input_lockout_enable_o(lk_en), .input_lockout_level_o(lk_lvl),
		.ext_current_resistor_enable_o(r_iset),
		.ext_switch_freq_enable_o(r_fsw), .ext_dim_freq_enable_o(r_fdim),
		.output_range_select_o(rng), .transition_time_ms_o(ttime),
		.smoothing_o(smooth), .hysteresis_bits_o(hyst));

	lcr_host_model host (.clk_i(clk_i), .sda_oe_i(sda_oe), .scl_o(scl),
		.sda_o(sda));

	// ----------------------------------------
	// checking tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic chk_out();
		logic [11:0] a;
		logic [2:0]  c;
		a = {sh[7][3:0], sh[6]};
		c = sh[7][6:4];
		chk("amplitude", amp, a);
		chk("ceiling", ceil, CEIL[c]);
		chk("led_current", cur, (CEIL[c] * a) >> 12);
		chk("transfer", xfer, XFER[sh[8][7:6]]);
		chk("lockout_en", lk_en, sh[8][5]);
		chk("lockout_lvl", lk_lvl, sh[8][4]);
		chk("ext_current_resistor_enable", r_iset, sh[8][2]);
		chk("fsw_en", r_fsw, sh[8][1]);
		chk("fdim_en", r_fdim, sh[8][0]);
		chk("range", rng, sh[9][7]);
		chk("time", ttime, TT[sh[9][6:4]]);
		chk("smooth", smooth, sh[9][3:2]);
		chk("hyst", hyst, HY[sh[9][1:0]]);
	endtask

	task automatic chk_stg();
		logic [2:0] c;
		logic       on;
		c = sh[5][5:3];
		on = (c != 3'h7) && (mode == 2'h2 || (mode == 2'h0 && !direct));
		chk("mix_active", mix_on, mode == 2'h2);
		chk("stagger_on", stg_on, on);
		chk("phases", stg_ph, on ? PH[c] : 1);
		chk("step_deg", stg_deg, on ? DEG[c] : 0);
	endtask

	// unmapped offsets are acked but leave the shadow alone
	task automatic wr(input logic [7:0] o, input logic [7:0] d);
		logic ok;
		host.write(DEV, o, {d, 8'h00}, 1, ok);
		if (o >= 8'h05 && o <= 8'h09)
			sh[o] = d & WM[o];
	endtask

	task automatic rd_chk(input logic [7:0] o);
		logic [7:0] d;
		host.read(DEV, o, d);
		chk("readback", d, sh[o]);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------
	// clock, watchdog and main sequence
	// ----------------------------------------
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	initial
	begin
		repeat (100000) @(posedge clk_i);
		chk("watchdog", 1'b0, 1'b1);
		close_out();
	end

	initial
	begin
		logic [7:0] o;
		logic [7:0] d;
		logic       ok;
		rst_b_i = 1'b0;
		mode = 2'h2;
		direct = 1'b0;
		for (int i = 5; i <= 9; i++)
			sh[i] = RST[i];
		void'($urandom(32'h1dff2a06));
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk_out();
		chk_stg();
		for (int i = 5; i <= 9; i++)
			rd_chk(8'(i));
		$display("test reset_values done");
		// all ones then all zeros first, to hit reserved bits
		for (int n = 0; n < 30; n++)
		begin
			o = 8'h05 + 8'($urandom_range(4));
			d = 8'($urandom);
			if (n < 10)
			begin
				o = 8'h05 + 8'(n % 5);
				d = (n < 5) ? 8'hFF : 8'h00;
			end
			wr(o, d);
			rd_chk(o);
			chk_out();
		end
		$display("test random_fields done");
		// slow host; burst across the lower window edge and up to the upper one
		host.half = 8;
		host.write(DEV, 8'h04, 16'hFF00, 2, ok);
		sh[5] = 8'h00;
		host.write(DEV, 8'h08, 16'h5A3C, 2, ok);
		sh[8] = 8'h5A & WM[8];
		sh[9] = 8'h3C;
		wr(8'h0A, 8'h77);
		host.read(DEV, 8'h0A, d);
		chk("unmapped", d, 8'h00);
		host.write(DEV ^ 7'h01, 8'h06, 16'h1200, 1, ok);
		for (int i = 5; i <= 9; i++)
			rd_chk(8'(i));
		chk_out();
		host.half = 3;
		$display("test burst_and_refusal done");
		for (int c = 0; c < 8; c++)
		begin
			wr(8'h05, 8'(c << 3));
			for (int m = 0; m < 8; m++)
			begin
				@(posedge clk_i);
				mode <= 2'(m >> 1);
				direct <= m[0];
				repeat (3) @(posedge clk_i);
				chk_stg();
			end
		end
		$display("test stagger_modes done");
		// reset again with the bus idle and registers 08 and 09 off default; stagger is back at 38 after the last stagger write
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		for (int i = 5; i <= 9; i++)
			sh[i] = RST[i];
		repeat (2) @(posedge clk_i);
		chk_out();
		chk_stg();
		for (int i = 5; i <= 9; i++)
			rd_chk(8'(i));
		$display("test mid_reset done");
		close_out();
	end
endmodule // tb_led_driver_config_regs_05_09

`default_nettype wire
